// [adc_conversion_power_control_tb_top.sv]
// testbench joining host and converter ends, plus a converter driven directly
`timescale 1ns/100ps

module adc_conversion_power_control_tb_top;
  typedef struct packed
  {
    logic [6:0]                    word;
    logic                          nap;
    logic [15:0]                   smp;
    logic [15:0]                   res;
    adc_link_pkg::power_state_type pwr;
  } row_type;

  logic core_clk = 1'b0;
  logic sys_rst  = 1'b1;
  logic [15:0] sampleIn = 16'h0000;
  logic cmdValid = 1'b0;
  logic [6:0] cmdWord = 7'h00;
  logic cmdNap = 1'b0;
  logic resReady = 1'b0;
  logic sampleTaken, coreOn, refBufOn, converting, cmdReady, resValid, waking;
  logic fSampleTaken, fCoreOn, fRefBufOn, fConverting;
  logic [5:0] muxCfg, fMuxCfg;
  logic [15:0] resData;
  adc_link_pkg::power_state_type powerState, fPowerState;
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;
  int fTaken = 0;
  row_type rows [5] = '{
    '{7'h02, 1'b0, 16'h8123, 16'h0123, adc_link_pkg::PWR_ON},
    '{7'h00, 1'b1, 16'h1234, 16'h1234, adc_link_pkg::PWR_NAP},
    '{7'h01, 1'b0, 16'hFFFF, 16'h7FFF, adc_link_pkg::PWR_SLEEP},
    '{7'h7E, 1'b0, 16'h0000, 16'h8000, adc_link_pkg::PWR_ON},
    '{7'h00, 1'b1, 16'hA5A5, 16'hA5A5, adc_link_pkg::PWR_NAP}};

  adc_link_if adc_link_if_i ();
  adc_link_if faultLink ();

  conv_dev_end conv_dev_end_i (.core_clk(core_clk), .sys_rst(sys_rst), .link(adc_link_if_i.dev),
    .sampleIn(sampleIn), .sampleTaken(sampleTaken), .muxCfg(muxCfg), .powerState(powerState),
    .coreOn(coreOn), .refBufOn(refBufOn), .converting(converting));
  conv_dev_end conv_dev_end_fault_i (.core_clk(core_clk), .sys_rst(sys_rst), .link(faultLink.dev),
    .sampleIn(16'h0001), .sampleTaken(fSampleTaken), .muxCfg(fMuxCfg), .powerState(fPowerState),
    .coreOn(fCoreOn), .refBufOn(fRefBufOn), .converting(fConverting));
  conv_host_end #(.WAKE_CYCLES(50)) conv_host_end_i (.core_clk(core_clk), .sys_rst(sys_rst),
    .link(adc_link_if_i.host), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdWord(cmdWord),
    .cmdNap(cmdNap), .resValid(resValid), .resReady(resReady), .resData(resData), .waking(waking));
  adc_link_assertions adc_link_assertions_i (.core_clk(core_clk), .sys_rst(sys_rst),
    .conversionSelect(adc_link_if_i.conversionSelect), .sck(adc_link_if_i.sck), .sdi(adc_link_if_i.sdi),
    .sdo(adc_link_if_i.sdo), .converting(converting), .sampleTaken(sampleTaken),
    .powerState(powerState), .coreOn(coreOn), .refBufOn(refBufOn));

  // ----------------------------------------
  // clock, timeout and shared tasks
  // ----------------------------------------
  always #2 core_clk = ~core_clk;

  always @(negedge core_clk)
    if (fSampleTaken === 1'b1)
      fTaken++;

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      fails++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    $display("checks_done %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // called at a falling edge; a command is taken at the rise after cmdReady is seen high
  task automatic issue(input logic [6:0] word, input logic nap, input logic [15:0] smp,
                       input int lim, input logic expTaken);
    int n;
    n = 0;
    sampleIn = smp;
    cmdWord  = word;
    cmdNap   = nap;
    cmdValid = 1'b1;
    while (cmdReady !== 1'b1 && n < lim)
    begin
      @(negedge core_clk);
      n++;
    end
    @(negedge core_clk);
    cmdValid = 1'b0;
    check("cmdTaken", {15'h0000, expTaken}, {15'h0000, n < lim});
    // sampleIn must stand until the converter has captured it, three edges after the take
    repeat (3) @(negedge core_clk);
    check("sampleTaken", {15'h0000, expTaken}, {15'h0000, sampleTaken});
  endtask

  task automatic pop(input logic [15:0] exp);
    int n;
    n = 0;
    while (resValid !== 1'b1 && n < 3000)
    begin
      @(negedge core_clk);
      n++;
    end
    check("resData", exp, resData);
    resReady = 1'b1;
    @(negedge core_clk);
    resReady = 1'b0;
    @(negedge core_clk);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    int i;
    int n;
    faultLink.conversionSelect = 1'b0;
    faultLink.sck = 1'b0;
    faultLink.sdi = 1'b0;
    repeat (3) @(negedge core_clk);
    sys_rst = 1'b0;
    for (i = 0; i < 5; i++)
    begin
      issue(rows[i].word, rows[i].nap, rows[i].smp, 3000, 1'b1);
      pop(rows[i].res);
      check("powerState", 16'(rows[i].pwr), 16'(powerState));
      check("muxCfg", {10'h000, rows[i].word[6:1]}, {10'h000, muxCfg});
      if (i == 3)
        check("waking", 16'h0001, {15'h0000, waking});
    end
    // fifo filled until commands are refused, then drained
    for (i = 0; i < 8; i++)
      issue(7'h00, 1'b0, {i[3:0], 12'h5A0}, 3000, 1'b1);
    issue(7'h00, 1'b0, 16'h0000, 2000, 1'b0);
    for (i = 0; i < 8; i++)
      pop({1'b1, i[2:0], 12'h5A0});
    check("resValid", 16'h0000, {15'h0000, resValid});
    // reset in the middle of a napping conversion
    issue(7'h00, 1'b1, 16'h0000, 3000, 1'b1);
    repeat (100) @(negedge core_clk);
    sys_rst = 1'b1;
    repeat (2) @(negedge core_clk);
    check("rstConv", 16'h0000, {15'h0000, converting});
    check("rstPower", 16'(adc_link_pkg::PWR_ON), 16'(powerState));
    check("rstOn", 16'h0003, {14'h0000, coreOn, refBufOn});
    check("rstSel", 16'h0000, {15'h0000, adc_link_if_i.conversionSelect});
    check("rstRes", 16'h0000, {15'h0000, resValid});
    sys_rst = 1'b0;
    repeat (3) @(negedge core_clk);
    // directly driven converter: short pulse, then a start edge and serial noise mid conversion
    fTaken = 0;
    faultLink.conversionSelect = 1'b1;
    repeat (5) @(negedge core_clk);
    faultLink.conversionSelect = 1'b0;
    repeat (100) @(negedge core_clk);
    faultLink.conversionSelect = 1'b1;
    repeat (8)
    begin
      repeat (8) @(negedge core_clk);
      faultLink.sck = ~faultLink.sck;
      faultLink.sdi = ~faultLink.sdi;
    end
    faultLink.conversionSelect = 1'b0;
    n = 0;
    while (fConverting !== 1'b0 && n < 2000)
    begin
      @(negedge core_clk);
      n++;
    end
    repeat (3) @(negedge core_clk);
    check("faultSdo", 16'h0001, {15'h0000, faultLink.sdo});
    check("faultPower", 16'(adc_link_pkg::PWR_ON), 16'(fPowerState));
    check("faultStarts", 16'h0001, 16'(fTaken));
    check("faultMux", 16'h0000, {10'h000, fMuxCfg});
    end_of_test();
  end
endmodule

// [adc_link_assertions.sv]
// link checker for the converter end
`timescale 1ns/100ps
`include "adc_link_cfg.svh"

module adc_link_assertions
(
  // clock and reset
  input wire logic                          core_clk,
  input wire logic                          sys_rst,
  // link wires
  input wire logic                          conversionSelect,
  input wire logic                          sck,
  input wire logic                          sdi,
  input wire logic                          sdo,
  // converter status
  input wire logic                          converting,
  input wire logic                          sampleTaken,
  input wire adc_link_pkg::power_state_type powerState,
  input wire logic                          coreOn,
  input wire logic                          refBufOn
);
  localparam int CONV_LO = `CONV_CYCLES - 4;
  localparam int CONV_HI = `CONV_CYCLES + 2;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  logic [10:0] convCnt_ff;
  logic [1:0]  takenCnt_ff;

  // ----------------------------------------
  // helper counters
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst)
    if (sys_rst)
      convCnt_ff <= 11'h000;
    else
      convCnt_ff <= converting ? convCnt_ff + 11'h001 : 11'h000;

  // starts seen within one conversion
  always_ff @(posedge core_clk or posedge sys_rst)
    if (sys_rst)
      takenCnt_ff <= 2'h0;
    else if (!converting && !sampleTaken)
      takenCnt_ff <= 2'h0;
    else if (sampleTaken && takenCnt_ff != 2'h3)
      takenCnt_ff <= takenCnt_ff + 2'h1;

  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_startEdge;
    $rose(conversionSelect) && !converting |-> ##[1:6] converting;
  endproperty
  a_startEdge: assert property (p_startEdge) else $error("select rise started no conversion");

  property p_convTime;
    $fell(converting) |-> convCnt_ff >= CONV_LO && convCnt_ff <= CONV_HI;
  endproperty
  a_convTime: assert property (p_convTime) else $error("conversion length out of range");

  property p_oneStart;
    takenCnt_ff <= 2'h1;
  endproperty
  a_oneStart: assert property (p_oneStart) else $error("second start inside a conversion");

  property p_napEnter;
    $fell(converting) && conversionSelect |-> ##[1:4] powerState == adc_link_pkg::PWR_NAP;
  endproperty
  a_napEnter: assert property (p_napEnter) else $error("no nap with select high at end");

  property p_stayOn;
    $fell(converting) && !conversionSelect && powerState == adc_link_pkg::PWR_ON
      |=> (powerState == adc_link_pkg::PWR_ON)[*4];
  endproperty
  a_stayOn: assert property (p_stayOn) else $error("power left on state with select low");

  property p_napPower;
    powerState == adc_link_pkg::PWR_NAP && $past(powerState) == adc_link_pkg::PWR_NAP |-> refBufOn && !coreOn;
  endproperty
  a_napPower: assert property (p_napPower) else $error("nap power enables wrong");

  property p_sleepPower;
    powerState == adc_link_pkg::PWR_SLEEP && $past(powerState) == adc_link_pkg::PWR_SLEEP |-> !refBufOn && !coreOn;
  endproperty
  a_sleepPower: assert property (p_sleepPower) else $error("sleep power enables wrong");

  property p_quietPort;
    converting && $past(converting) |-> $stable(sdo);
  endproperty
  a_quietPort: assert property (p_quietPort) else $error("sdo moved during conversion");
endmodule

// [adc_link_cfg.svh]
// timing counts, widths and word field positions for the converter link
`ifndef ADC_LINK_CFG_SVH
`define ADC_LINK_CFG_SVH

`define CLK_PERIOD_NS     4
`define CONV_TIME_NS      3500
`define CONV_CYCLES       (`CONV_TIME_NS / `CLK_PERIOD_NS)
`define SEL_EARLY_NS      100
`define SEL_EARLY_CYCLES  (`SEL_EARLY_NS / `CLK_PERIOD_NS)
`define SEL_PULSE_NS      40
`define SEL_PULSE_CYCLES  (`SEL_PULSE_NS / `CLK_PERIOD_NS)
`define CONV_MARGIN       8
`define SCK_HALF_CYCLES   8
`define WAKE_TIME_MS      60
`define WAKE_CYCLES       ((`WAKE_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`define RESULT_BITS       16
`define WORD_BITS         7
`define FIFO_DEPTH        8
`define WORD_SD_BIT       6
`define WORD_OS_BIT       5
`define WORD_S1_BIT       4
`define WORD_S0_BIT       3
`define WORD_COM_BIT      2
`define WORD_UNI_BIT      1
`define WORD_SLEEP_BIT    0
`define WORD_RESET_VALUE  7'h00

`endif

// [adc_link_if.sv]
// link wires between host and converter
`timescale 1ns/100ps
interface adc_link_if;
  logic conversionSelect;
  logic sck;
  logic sdi;
  logic sdo;

  modport dev (input conversionSelect, input sck, input sdi, output sdo);
  modport host (output conversionSelect, output sck, output sdi, input sdo);
endinterface

// [adc_link_pkg.sv]
// types and shared coding function for the converter link
package adc_link_pkg;

  typedef enum logic [1:0] {PWR_ON, PWR_NAP, PWR_SLEEP} power_state_type;

  typedef enum logic [2:0] {H_IDLE, H_START, H_CONV, H_SHIFT, H_DONE} host_state_type;

  // offset binary sample to output code: two's complement when bipolar
  function automatic logic [15:0] encodeResult(input logic [15:0] raw, input logic unipolar);
    encodeResult = unipolar ? raw : {~raw[15], raw[14:0]};
  endfunction

endpackage

// [conv_dev_end.sv]
// converter end: conversion start, power states and serial result port
//
// Overview of operation
// - select high at conversion end enters nap
// - nap keeps only reference and buffer powered
// - host drops select early or after conversion
// - select low at end presents MSB
// - select low at end stays fully powered
// - sleep bit set enters sleep mode
// - host waits wake time after sleep release
// - a select rising edge starts a conversion when none is running
// - start edges ignored while converting
// - host keeps serial pins static during conversion
// - serial port ignores clock and data while converting
// - host avoids shared bus traffic while converting
// - bipolar two's complement, unipolar straight binary
// - conversion ends within fixed maximum time
// - select low after conversion enables port
`timescale 1ns/100ps
`include "adc_link_cfg.svh"

module conv_dev_end
(
  // clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         sys_rst,
  // link to host
  adc_link_if.dev                           link,
  // sampled analog value, offset binary
  input  wire logic [15:0]                  sampleIn,
  // user side status
  output logic                              sampleTaken,
  output logic [5:0]                        muxCfg,
  output adc_link_pkg::power_state_type     powerState,
  output logic                              coreOn,
  output logic                              refBufOn,
  output logic                              converting
);

  localparam logic [9:0] CONV_LAST = 10'(`CONV_CYCLES - 1);
  localparam logic [4:0] WORD_LAST = 5'(`WORD_BITS - 1);
  localparam logic [4:0] FRAME_LAST = 5'(`RESULT_BITS - 1);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic convMeta_ff;
  logic convSel_ff;
  logic convPrev_ff;
  logic sckMeta_ff;
  logic sck_ff;
  logic sckPrev_ff;
  logic sdiMeta_ff;
  logic sdi_ff;

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      convMeta_ff <= 1'b0;
      convSel_ff  <= 1'b0;
      convPrev_ff <= 1'b0;
      sckMeta_ff  <= 1'b0;
      sck_ff      <= 1'b0;
      sckPrev_ff  <= 1'b0;
      sdiMeta_ff  <= 1'b0;
      sdi_ff      <= 1'b0;
    end
    else
    begin
      convMeta_ff <= link.conversionSelect;
      convSel_ff  <= convMeta_ff;
      convPrev_ff <= convSel_ff;
      sckMeta_ff  <= link.sck;
      sck_ff      <= sckMeta_ff;
      sckPrev_ff  <= sck_ff;
      sdiMeta_ff  <= link.sdi;
      sdi_ff      <= sdiMeta_ff;
    end
  end

  logic convRise;
  logic sckRise;
  logic sckFall;

  assign convRise = convSel_ff & ~convPrev_ff;
  assign sckRise  = sck_ff & ~sckPrev_ff;
  assign sckFall  = ~sck_ff & sckPrev_ff;

  // ----------------------------------------------------------------
  // conversion timing
  // ----------------------------------------------------------------
  logic       convBusy_ff;
  logic [9:0] convCnt_ff;
  logic       convStart;
  logic       convDone;

  assign convStart = convRise & ~convBusy_ff;
  assign convDone  = convBusy_ff & (convCnt_ff == CONV_LAST);

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      convBusy_ff <= 1'b0;
      convCnt_ff  <= 10'h000;
    end
    else if (convStart)
    begin
      convBusy_ff <= 1'b1;
      convCnt_ff  <= 10'h000;
    end
    else if (convDone)
    begin
      convBusy_ff <= 1'b0;
    end
    else if (convBusy_ff)
    begin
      convCnt_ff <= convCnt_ff + 10'h001;
    end
  end

  // ----------------------------------------------------------------
  // sample hold and result coding
  // ----------------------------------------------------------------
  logic [15:0] heldSample_ff;
  logic [15:0] codedResult;
  logic [6:0]  cfgWord_ff;

  assign codedResult = adc_link_pkg::encodeResult(heldSample_ff, cfgWord_ff[`WORD_UNI_BIT]);

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      heldSample_ff <= 16'h0000;
    else if (convStart)
      heldSample_ff <= sampleIn;
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      sampleTaken <= 1'b0;
    else
      sampleTaken <= convStart;
  end

  // ----------------------------------------------------------------
  // serial port
  // ----------------------------------------------------------------
  logic        resultReady_ff;
  logic        portEn;
  logic [15:0] shift_ff;
  logic [6:0]  inWord_ff;
  logic [4:0]  bitCnt_ff;
  logic [6:0]  nxt_inWord;
  logic        wordApply;
  logic        sdo_ff;

  // port stays deaf while a conversion runs
  assign portEn     = resultReady_ff & ~convBusy_ff & ~convSel_ff;
  assign nxt_inWord = {inWord_ff[5:0], sdi_ff};
  assign wordApply  = portEn & sckRise & (bitCnt_ff == WORD_LAST);

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      resultReady_ff <= 1'b0;
    else if (convStart)
      resultReady_ff <= 1'b0;
    else if (convDone)
      resultReady_ff <= 1'b1;
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      shift_ff <= 16'h0000;
    else if (convDone)
      shift_ff <= codedResult;
    else if (portEn & sckFall)
      shift_ff <= {shift_ff[14:0], 1'b0};
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      inWord_ff <= `WORD_RESET_VALUE;
      bitCnt_ff <= 5'h00;
    end
    else if (convStart)
    begin
      bitCnt_ff <= 5'h00;
    end
    else if (portEn & sckRise & (bitCnt_ff != FRAME_LAST + 5'h01))
    begin
      inWord_ff <= nxt_inWord;
      bitCnt_ff <= bitCnt_ff + 5'h01;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      cfgWord_ff <= `WORD_RESET_VALUE;
    else if (wordApply)
      cfgWord_ff <= nxt_inWord;
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      sdo_ff <= 1'b0;
    else if (convDone & ~convSel_ff)
      sdo_ff <= codedResult[15];
    else if (portEn)
      sdo_ff <= shift_ff[15];
  end

  assign link.sdo = sdo_ff;

  // ----------------------------------------------------------------
  // power state
  // ----------------------------------------------------------------
  adc_link_pkg::power_state_type power_ff;
  adc_link_pkg::power_state_type nxt_power;

  always_comb
  begin
    nxt_power = power_ff;
    if (wordApply & nxt_inWord[`WORD_SLEEP_BIT])
      nxt_power = adc_link_pkg::PWR_SLEEP;
    else if (wordApply & (power_ff == adc_link_pkg::PWR_SLEEP))
      nxt_power = adc_link_pkg::PWR_ON;
    else if (power_ff != adc_link_pkg::PWR_SLEEP)
    begin
      if (convDone)
        nxt_power = convSel_ff ? adc_link_pkg::PWR_NAP : adc_link_pkg::PWR_ON;
      else if (convStart)
        nxt_power = adc_link_pkg::PWR_ON;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      power_ff <= adc_link_pkg::PWR_ON;
    else
      power_ff <= nxt_power;
  end

  // ----------------------------------------------------------------
  // registered status outputs
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      powerState <= adc_link_pkg::PWR_ON;
      coreOn     <= 1'b1;
      refBufOn   <= 1'b1;
      converting <= 1'b0;
      muxCfg     <= 6'h00;
    end
    else
    begin
      powerState <= nxt_power;
      coreOn     <= (nxt_power == adc_link_pkg::PWR_ON);
      refBufOn   <= (nxt_power != adc_link_pkg::PWR_SLEEP);
      converting <= convStart | (convBusy_ff & ~convDone);
      muxCfg     <= cfgWord_ff[6:1];
    end
  end

endmodule

// [conv_host_end.sv]
// host end: result fifo and the link master that starts and reads conversions
`timescale 1ns/100ps
`include "adc_link_cfg.svh"

module result_fifo
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
)
(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  // fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0]      wrPtr_ff;
  logic [AW:0]      rdPtr_ff;
  logic             push;
  logic             pop;

  assign inReady  = (wrPtr_ff[AW] == rdPtr_ff[AW]) | (wrPtr_ff[AW-1:0] != rdPtr_ff[AW-1:0]);
  assign outValid = (wrPtr_ff != rdPtr_ff);
  assign outData  = mem_ff[rdPtr_ff[AW-1:0]];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  always_ff @(posedge core_clk)
  begin
    if (push)
      mem_ff[wrPtr_ff[AW-1:0]] <= inData;
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
    end
    else
    begin
      if (push)
        wrPtr_ff <= wrPtr_ff + (AW+1)'(1);
      if (pop)
        rdPtr_ff <= rdPtr_ff + (AW+1)'(1);
    end
  end

endmodule

module conv_host_end
#(
  parameter int unsigned WAKE_CYCLES = `WAKE_CYCLES
)
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // link to converter
  adc_link_if.host         link,
  // command side
  input  wire logic        cmdValid,
  output logic             cmdReady,
  input  wire logic [6:0]  cmdWord,
  input  wire logic        cmdNap,
  // result side
  output logic             resValid,
  input  wire logic        resReady,
  output logic [15:0]      resData,
  // status
  output logic             waking
);

  localparam logic [11:0] PULSE_LAST = 12'(`SEL_PULSE_CYCLES - 1);
  localparam logic [11:0] CONV_WAIT  = 12'(`CONV_CYCLES + `CONV_MARGIN);
  localparam logic [3:0]  HALF_LAST  = 4'(`SCK_HALF_CYCLES - 1);
  localparam logic [4:0]  BITS       = 5'(`RESULT_BITS);

  // ----------------------------------------------------------------
  // sdo synchroniser and result fifo
  // ----------------------------------------------------------------
  logic        sdoMeta_ff;
  logic        sdo_ff;
  logic        fifoReady;
  logic        push_ff;
  logic [15:0] rx_ff;

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sdoMeta_ff <= 1'b0;
      sdo_ff     <= 1'b0;
    end
    else
    begin
      sdoMeta_ff <= link.sdo;
      sdo_ff     <= sdoMeta_ff;
    end
  end

  result_fifo #(.WIDTH(`RESULT_BITS), .DEPTH(`FIFO_DEPTH)) resultBuf
  (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .inValid  (push_ff),
    .inReady  (fifoReady),
    .inData   (rx_ff),
    .outValid (resValid),
    .outReady (resReady),
    .outData  (resData)
  );

  // ----------------------------------------------------------------
  // link master
  // ----------------------------------------------------------------
  adc_link_pkg::host_state_type state_ff;
  logic [11:0] cnt_ff;
  logic [3:0]  half_ff;
  logic [4:0]  bits_ff;
  logic [6:0]  word_ff;
  logic        nap_ff;
  logic        sel_ff;
  logic        sck_ff;
  logic        sdi_ff;
  logic        asleep_ff;
  logic [31:0] wakeCnt_ff;
  logic        halfEnd;

  assign halfEnd = (half_ff == HALF_LAST);

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_ff <= adc_link_pkg::H_IDLE;
      cnt_ff   <= 12'h000;
      half_ff  <= 4'h0;
      bits_ff  <= 5'h00;
      word_ff  <= `WORD_RESET_VALUE;
      nap_ff   <= 1'b0;
      sel_ff   <= 1'b0;
      sck_ff   <= 1'b0;
      sdi_ff   <= 1'b0;
      rx_ff    <= 16'h0000;
      push_ff  <= 1'b0;
      cmdReady <= 1'b0;
    end
    else
    begin
      push_ff <= 1'b0;
      unique case (state_ff)
        adc_link_pkg::H_IDLE:
        begin
          // a push still in flight leaves fifoReady one cycle stale, so it blocks a new command too
          cmdReady <= fifoReady & ~push_ff & ~waking & ~cmdReady;
          if (cmdValid & cmdReady)
          begin
            cmdReady <= 1'b0;
            word_ff  <= cmdWord;
            nap_ff   <= cmdNap;
            sel_ff   <= 1'b1;
            cnt_ff   <= 12'h000;
            state_ff <= adc_link_pkg::H_START;
          end
        end
        adc_link_pkg::H_START:
        begin
          cnt_ff <= cnt_ff + 12'h001;
          if (cnt_ff == PULSE_LAST)
          begin
            sel_ff   <= nap_ff;
            state_ff <= adc_link_pkg::H_CONV;
          end
        end
        adc_link_pkg::H_CONV:
        begin
          cnt_ff <= cnt_ff + 12'h001;
          if (cnt_ff == CONV_WAIT)
          begin
            sel_ff   <= 1'b0;
            sdi_ff   <= word_ff[6];
            half_ff  <= 4'h0;
            bits_ff  <= 5'h00;
            state_ff <= adc_link_pkg::H_SHIFT;
          end
        end
        adc_link_pkg::H_SHIFT:
        begin
          half_ff <= halfEnd ? 4'h0 : half_ff + 4'h1;
          if (halfEnd & ~sck_ff)
          begin
            sck_ff  <= 1'b1;
            rx_ff   <= {rx_ff[14:0], sdo_ff};
            bits_ff <= bits_ff + 5'h01;
          end
          else if (halfEnd)
          begin
            sck_ff  <= 1'b0;
            word_ff <= {word_ff[5:0], 1'b0};
            sdi_ff  <= word_ff[5];
            if (bits_ff == BITS)
              state_ff <= adc_link_pkg::H_DONE;
          end
        end
        adc_link_pkg::H_DONE:
        begin
          sdi_ff   <= 1'b0;
          push_ff  <= 1'b1;
          state_ff <= adc_link_pkg::H_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // sleep tracking and wake-up wait
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      asleep_ff  <= 1'b0;
      waking     <= 1'b0;
      wakeCnt_ff <= 32'h0000_0000;
    end
    else if (state_ff == adc_link_pkg::H_START && cnt_ff == 12'h000)
    begin
      if (word_ff[`WORD_SLEEP_BIT])
        asleep_ff <= 1'b1;
      else if (asleep_ff)
      begin
        asleep_ff  <= 1'b0;
        waking     <= 1'b1;
        wakeCnt_ff <= 32'h0000_0000;
      end
    end
    else if (waking & (state_ff == adc_link_pkg::H_IDLE))
    begin
      wakeCnt_ff <= wakeCnt_ff + 32'h0000_0001;
      if (wakeCnt_ff >= WAKE_CYCLES - 1)
        waking <= 1'b0;
    end
  end

  assign link.conversionSelect = sel_ff;
  assign link.sck              = sck_ff;
  assign link.sdi              = sdi_ff;

endmodule
